// ---- logic/srpt_pkg.sv ----
// constants for the status reporting core
// assumes a single clock domain and an external command decoder
// Function
// - any programming error sets one or more error bits in event flags
// - reading event flags returns contents, then clears all bits
// - masked event bits are ORed into status byte bit 5
// - operation complete command sets event bit 0 when pending work ends
// - empty queue read or lost queue data sets event bit 2
// - memory loss or self-test failure sets event bit 3
// - bad parameter or impossible execution sets event bit 4
// - syntax, semantic error or trigger inside message sets event bit 5
// - status byte readable both by serial poll and by query
// - serial poll returns request-service in bit 6, then clears only it
// - query returns master summary in bit 6, status byte unchanged
// - clear-status command clears only the request-service bit of the status byte
// - status byte bit 2 shows enabled channel summary event
// - status byte bit 3 shows enabled questionable event
// - status byte bit 4 shows output queue holds data
// - status byte bit 5 shows enabled standard event
// - service request enable mask selects bits able to request service
// - event flags latch only on rising edge of their source
package srpt_pkg;
   localparam int EV_OPC_BIT = 0;
   localparam int EV_QRY_BIT = 2;
   localparam int EV_DEV_BIT = 3;
   localparam int EV_EXE_BIT = 4;
   localparam int EV_CMD_BIT = 5;
   localparam int SB_CHAN_BIT = 2;
   localparam int SB_QUES_BIT = 3;
   localparam int SB_MSGA_BIT = 4;
   localparam int SB_EVS_BIT = 5;
   localparam int SB_RQS_BIT = 6;
   localparam logic [7:0] EV_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] SRE_RESET = 8'h00;
   localparam logic [7:0] EV_USED = 8'h3D;
endpackage

// ---- logic/srpt_status.sv ----
// standard event flags, status byte and service request logic
// assumes command decoder pulses on clk_in and sync sources from same clock
`timescale 1ns/10ps
module srpt_status (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       opc_done_in,
   input  wire logic       query_err_in,
   input  wire logic       dev_err_in,
   input  wire logic       exec_err_in,
   input  wire logic       cmd_err_in,
   input  wire logic       esr_read_in,
   input  wire logic       ese_wr_in,
   input  wire logic [7:0] ese_data_in,
   input  wire logic       sre_wr_in,
   input  wire logic [7:0] sre_data_in,
   input  wire logic       channel_summary_flag_in,
   input  wire logic       ques_summary_in,
   input  wire logic       msg_avail_in,
   input  wire logic       poll_in,
   input  wire logic       stb_query_in,
   input  wire logic       cls_in,
   output logic [7:0]      esr_data_out,
   output logic [7:0]      stb_data_out,
   output logic            stb_valid_out,
   output logic            srq_out
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] src_now;
   logic [7:0] src_reg;
   logic [7:0] ev_reg;
   logic [7:0] ese_reg;
   logic [7:0] sre_reg;
   logic [7:0] stb_reg;
   logic [7:0] rise;
   logic [7:0] stb_now;
   logic       mss;
   logic       mss_reg;
   logic       rqs_reg;

   always_comb begin
      src_now = 8'h00;
      src_now[srpt_pkg::EV_OPC_BIT] = opc_done_in;
      src_now[srpt_pkg::EV_QRY_BIT] = query_err_in;
      src_now[srpt_pkg::EV_DEV_BIT] = dev_err_in;
      src_now[srpt_pkg::EV_EXE_BIT] = exec_err_in;
      src_now[srpt_pkg::EV_CMD_BIT] = cmd_err_in;
   end

   assign rise = src_now & ~src_reg & srpt_pkg::EV_USED;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_reg <= srpt_pkg::EV_RESET;
      end else if (ce_in) begin
         src_reg <= src_now;
      end
   end

   ////////////////////////////////////////////////////////////////
   // same-cycle rises go out in the read data, then all flags clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ev_reg       <= srpt_pkg::EV_RESET;
         esr_data_out <= 8'h00;
      end else if (ce_in) begin
         if (esr_read_in) begin
            esr_data_out <= ev_reg | rise;
            ev_reg       <= 8'h00;
         end else begin
            ev_reg <= ev_reg | rise;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ese_reg <= srpt_pkg::MASK_RESET;
         sre_reg <= srpt_pkg::SRE_RESET;
      end else if (ce_in) begin
         if (ese_wr_in) begin
            ese_reg <= ese_data_in;
         end
         if (sre_wr_in) begin
            sre_reg <= sre_data_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      stb_now = 8'h00;
      stb_now[srpt_pkg::SB_CHAN_BIT] = channel_summary_flag_in;
      stb_now[srpt_pkg::SB_QUES_BIT] = ques_summary_in;
      stb_now[srpt_pkg::SB_MSGA_BIT] = msg_avail_in;
      stb_now[srpt_pkg::SB_EVS_BIT]  = |(ev_reg & ese_reg);
      mss = |(stb_now & sre_reg & ~(8'h01 << srpt_pkg::SB_RQS_BIT));
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stb_reg <= 8'h00;
         mss_reg <= 1'b0;
      end else if (ce_in) begin
         stb_reg <= stb_now;
         mss_reg <= mss;
      end
   end

   // rqs set on the rising summary; set beats poll clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rqs_reg <= 1'b0;
      end else if (ce_in) begin
         if (mss && !mss_reg) begin
            rqs_reg <= 1'b1;
         end else if (poll_in || cls_in) begin
            rqs_reg <= 1'b0;
         end
      end
   end

   assign srq_out = rqs_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stb_data_out  <= 8'h00;
         stb_valid_out <= 1'b0;
      end else if (ce_in) begin
         stb_valid_out <= poll_in || stb_query_in;
         if (poll_in) begin
            stb_data_out <= {stb_reg[7], rqs_reg, stb_reg[5:0]};
         end else if (stb_query_in) begin
            stb_data_out <= {stb_reg[7], mss_reg, stb_reg[5:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && esr_read_in |=> ev_reg == 8'h00 || $past(rise) != 8'h00)
      else $error("event flags not cleared by read");
   a_rise_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rise[srpt_pkg::EV_CMD_BIT] && !esr_read_in
      |=> ev_reg[srpt_pkg::EV_CMD_BIT])
      else $error("command error not latched");
   a_level_nolatch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && esr_read_in && rise == 8'h00 ##1 ce_in && $stable(src_now)
      |=> ev_reg == 8'h00)
      else $error("steady level relatched");
   a_esb_summary: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (ev_reg & ese_reg) != 8'h00 |=> stb_reg[srpt_pkg::SB_EVS_BIT])
      else $error("event summary wrong");
   a_rqs_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && mss && !mss_reg |=> rqs_reg)
      else $error("request service not raised");
   a_poll_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && poll_in && !(mss && !mss_reg) |=> !rqs_reg
      && stb_data_out[srpt_pkg::SB_RQS_BIT] == $past(rqs_reg))
      else $error("poll did not return and clear rqs");
   a_query_mss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && stb_query_in && !poll_in
      |=> stb_data_out[srpt_pkg::SB_RQS_BIT] == $past(mss_reg))
      else $error("query bit 6 not master summary");
   a_query_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && stb_query_in && !poll_in && !cls_in && !(mss && !mss_reg)
      |=> rqs_reg == $past(rqs_reg))
      else $error("query changed status byte");
   a_mav_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in |=> stb_reg[srpt_pkg::SB_MSGA_BIT] == $past(msg_avail_in))
      else $error("message available bit wrong");
   a_cls_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && cls_in && !(mss && !mss_reg) |=> !rqs_reg)
      else $error("clear status left rqs");

   ////////////////////////////////////////////////////////////////
   // request steps as seen at the taking edge
   sequence s_read_taken;
      ce_in && esr_read_in;
   endsequence

   sequence s_poll_taken;
      ce_in && poll_in;
   endsequence

   sequence s_query_taken;
      ce_in && stb_query_in && !poll_in;
   endsequence

   sequence s_quiet;
      ce_in && !esr_read_in;
   endsequence

   ////////////////////////////////////////////////////////////////
   a_read_returns: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_read_taken
      |=> (esr_data_out & $past(ev_reg)) == $past(ev_reg))
      else $error("read lost a held flag");

   a_read_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_read_taken
      |=> (esr_data_out & $past(rise)) == $past(rise))
      else $error("read lost a same-cycle rise");

   a_esr_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && esr_read_in)
      |=> $stable(esr_data_out))
      else $error("event read data moved without read");

   a_unused_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ev_reg & ~srpt_pkg::EV_USED) == 8'h00)
      else $error("unused event bit set");

   a_ev_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_quiet
      |=> (ev_reg & $past(ev_reg)) == $past(ev_reg))
      else $error("event flag dropped without read");

   a_quiet_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && !esr_read_in && rise == 8'h00
      |=> ev_reg == $past(ev_reg))
      else $error("event flag set without rising source");

   a_opc_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rise[srpt_pkg::EV_OPC_BIT] && !esr_read_in
      |=> ev_reg[srpt_pkg::EV_OPC_BIT])
      else $error("operation complete not latched");

   a_qry_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rise[srpt_pkg::EV_QRY_BIT] && !esr_read_in
      |=> ev_reg[srpt_pkg::EV_QRY_BIT])
      else $error("query error not latched");

   a_dev_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rise[srpt_pkg::EV_DEV_BIT] && !esr_read_in
      |=> ev_reg[srpt_pkg::EV_DEV_BIT])
      else $error("device error not latched");

   a_exe_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rise[srpt_pkg::EV_EXE_BIT] && !esr_read_in
      |=> ev_reg[srpt_pkg::EV_EXE_BIT])
      else $error("execution error not latched");

   // enable low must freeze the event flags, rqs, status byte and service enable mask
   a_ce_freeze: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ce_in
      |=> $stable(ev_reg) && $stable(rqs_reg) && $stable(stb_reg) && $stable(sre_reg))
      else $error("state moved with enable low");

   a_valid_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (poll_in || stb_query_in)
      |=> stb_valid_out)
      else $error("status answer not flagged");

   a_valid_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && !poll_in && !stb_query_in
      |=> !stb_valid_out)
      else $error("status flag without request");

   a_stb_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(ce_in && (poll_in || stb_query_in))
      |=> $stable(stb_data_out))
      else $error("status answer moved without request");

   a_chan_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in
      |=> stb_reg[srpt_pkg::SB_CHAN_BIT] == $past(channel_summary_flag_in))
      else $error("channel summary bit wrong");

   a_ques_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in
      |=> stb_reg[srpt_pkg::SB_QUES_BIT] == $past(ques_summary_in))
      else $error("questionable bit wrong");

   a_esb_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (ev_reg & ese_reg) == 8'h00
      |=> !stb_reg[srpt_pkg::SB_EVS_BIT])
      else $error("event summary set without enabled event");

   a_ese_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && ese_wr_in
      |=> ese_reg == $past(ese_data_in))
      else $error("event enable mask not written");

   a_sre_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && sre_wr_in
      |=> sre_reg == $past(sre_data_in))
      else $error("service enable mask not written");

   a_mss_masked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (stb_now & sre_reg) == 8'h00
      |=> !mss_reg)
      else $error("summary set by masked bit");

   a_mss_any: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && (stb_now & sre_reg) != 8'h00
      |=> mss_reg)
      else $error("summary missed an enabled bit");

   a_poll_rest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_poll_taken
      |=> stb_data_out[5:0] == $past(stb_reg[5:0]))
      else $error("poll returned wrong low bits");

   a_query_rest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_query_taken
      |=> stb_data_out[5:0] == $past(stb_reg[5:0]))
      else $error("query returned wrong low bits");

   a_rqs_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && rqs_reg && !poll_in && !cls_in
      |=> rqs_reg)
      else $error("request service dropped without poll");

   a_no_raise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && !rqs_reg && !(mss && !mss_reg)
      |=> !rqs_reg)
      else $error("request service raised without summary rise");
endmodule

// ---- verif/srpt_ctrl.sv ----
// bus controller model: serial poll, status query, clear, event read
// assumes the bench calls cmd from a single process
`timescale 1ns/10ps
module srpt_ctrl (
   input  wire logic clk_in,
   output logic      poll_out,
   output logic      query_out,
   output logic      cls_out,
   output logic      read_out
);
   initial {poll_out, query_out, cls_out, read_out} = 4'h0;
   // one-cycle strobe; k: 0 poll, 1 query, 2 clear, 3 event read
   task automatic cmd(input int k);
      @(posedge clk_in);
      {poll_out, query_out, cls_out, read_out} <= 4'h8 >> k;
      @(posedge clk_in);
      {poll_out, query_out, cls_out, read_out} <= 4'h0;
   endtask
endmodule

// ---- verif/ieee488_status_reporting_tb.sv ----
// bench for srpt_status: queued expectations, negedge monitor
// assumes ce_in held high except while one clear strobe is tested; controller model issues poll, query, clear and read, bench writes masks
`timescale 1ns/10ps
module ieee488_status_reporting_tb;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, ese_wr = 1'b0, sre_wr = 1'b0;
   logic        chan = 1'b0, ques = 1'b0, mav = 1'b0, rd_d = 1'b0, ce = 1'b1;
   logic [4:0]  src = 5'h00;
   logic [7:0]  ese = 8'h00, sre = 8'h00, esr_o, stb_o, eq[$], sq[$];
   logic [31:0] r;
   logic        poll, qry, cls, rd, stb_v, srq;
   int          err_count = 0, n_checks = 0, cyc = 0, seed = 32'h3ead231a;
   int          bits[5] = '{0, 2, 3, 4, 5};
   initial forever #5 clk_in = ~clk_in;
   srpt_ctrl srpt_ctrl_inst (.clk_in(clk_in), .poll_out(poll), .query_out(qry),
      .cls_out(cls), .read_out(rd));
   srpt_status srpt_status_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .opc_done_in(src[0]), .query_err_in(src[1]), .dev_err_in(src[2]),
      .exec_err_in(src[3]), .cmd_err_in(src[4]), .esr_read_in(rd), .ese_wr_in(ese_wr),
      .ese_data_in(ese), .sre_wr_in(sre_wr), .sre_data_in(sre),
      .channel_summary_flag_in(chan), .ques_summary_in(ques), .msg_avail_in(mav),
      .poll_in(poll), .stb_query_in(qry), .cls_in(cls), .esr_data_out(esr_o),
      .stb_data_out(stb_o), .stb_valid_out(stb_v), .srq_out(srq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic rd_esr(input logic [7:0] e);
      eq.push_back(e);
      srpt_ctrl_inst.cmd(3);
   endtask
   task automatic rd_stb(input int k, input logic [7:0] e);
      sq.push_back(e);
      srpt_ctrl_inst.cmd(k);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // negedge sampling keeps clear of the launching edge
   always @(negedge clk_in) begin
      if (rd_d) chk(esr_o, eq.pop_front());
      rd_d = rd;
      if (stb_v === 1'b1) chk(stb_o, sq.pop_front());
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      w(10);
      rst_n_in <= 1'b1;
      rd_esr(8'h00);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_in) src[i] <= 1'b1;
         w(3);
         rd_esr(8'h01 << bits[i]);
         w(2);
         rd_esr(8'h00);
         @(posedge clk_in) src[i] <= 1'b0;
      end
      // random enable masks; only bit 5 source raised
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         @(posedge clk_in) {ese, ese_wr, src[4]} <= {r[7:0], 2'b11};
         @(posedge clk_in) ese_wr <= 1'b0;
         w(3);
         rd_stb(1, {2'b00, r[5], 5'h00});
         rd_esr(8'h20);
         w(3);
         rd_stb(1, 8'h00);
         @(posedge clk_in) src[4] <= 1'b0;
      end
      @(posedge clk_in) {sre, sre_wr, chan, ques} <= {8'h10, 3'b111};
      @(posedge clk_in) sre_wr <= 1'b0;
      w(3);
      @(posedge clk_in) mav <= 1'b1;
      w(4);
      rd_stb(1, 8'h5C);
      rd_stb(0, 8'h5C);
      rd_stb(0, 8'h1C);
      rd_stb(1, 8'h5C);
      @(posedge clk_in) mav <= 1'b0;
      w(4);
      @(posedge clk_in) mav <= 1'b1;
      w(4);
      #1 chk({7'h00, srq}, 8'h01);
      // clear strobe with enable low must be ignored
      @(posedge clk_in) ce <= 1'b0;
      srpt_ctrl_inst.cmd(2);
      @(posedge clk_in) ce <= 1'b1;
      #1 chk({7'h00, srq}, 8'h01);
      srpt_ctrl_inst.cmd(2);
      w(2);
      #1 chk({7'h00, srq}, 8'h00);
      w(4);
      conclude();
   end
endmodule
